// ===== rtl/ssf_pkg.sv
// Constants and register map of the serial status flag block
//==================================================================
// Notes on behaviour
// - Status resets to 0x84, also on low-power entry
// - Flags clear by writing 0 after reading 1
// - Transmit buffer write clears buffer-empty flag
// - Buffer-empty sets on tx disable or shifter load
// - Good frame sets buffer-full; data read clears it
// - Errored frame or rx disabled: no buffer-full
// - Frame while buffer full: overrun, discard frame
// - Overrun halts receive; sync mode halts transmit
// - Async first stop bit low: framing error
// - Framing error still stores data, halts receive
// - Parity mismatch sets parity error, stores data
// - Framing/parity error halts rx; sync halts both
// - Rx disable leaves error and multiproc flags
// - Transmit done flag, read only, bit 2
// - Received multiproc bit captured in bit 1
// - Bit 0 sent as multiproc bit in async mp
// - Tx empty irq while enable and empty
// - Rx irqs withdrawn on flag or enable clear
// - Multiproc bit 1 sets flag, clears mp irq enable
package ssf_pkg;
  //==================================================================
  // Register byte offsets on the AHB-Lite slave
  localparam logic [7:0] SSF_STATUS_OFS  = 8'h00;
  localparam logic [7:0] SSF_CONTROL_OFS = 8'h04;
  localparam logic [7:0] SSF_TXBUF_OFS   = 8'h08;
  localparam logic [7:0] SSF_RXBUF_OFS   = 8'h0c;
  localparam logic [7:0] SSF_FORMAT_OFS  = 8'h10;
  localparam logic [7:0] SSF_IRQ_OFS     = 8'h14;

  //==================================================================
  // Status bit positions
  localparam int SSF_TDE  = 7;
  localparam int SSF_RDF  = 6;
  localparam int SSF_OVR  = 5;
  localparam int SSF_FRM  = 4;
  localparam int SSF_PAR  = 3;
  localparam int SSF_TND  = 2;
  localparam int SSF_MPR  = 1;
  localparam int SSF_MPT  = 0;

  // Control bit positions
  localparam int SSF_CTL_TIE  = 7;
  localparam int SSF_CTL_RIE  = 6;
  localparam int SSF_CTL_TE   = 5;
  localparam int SSF_CTL_RE   = 4;
  localparam int SSF_CTL_MULTIPROC_IRQ_ENABLE = 3;

  // Format bit positions
  localparam int SSF_FMT_SYNC = 7;
  localparam int SSF_FMT_PEN  = 5;
  localparam int SSF_FMT_ODD  = 4;
  localparam int SSF_FMT_MP   = 2;

  //==================================================================
  // Reset values
  localparam logic [7:0] SSF_STATUS_RST  = 8'h84;
  localparam logic [7:0] SSF_CONTROL_RST = 8'h00;
  localparam logic [7:0] SSF_FORMAT_RST  = 8'h00;
  localparam logic [7:0] SSF_CLEARABLE   = 8'hf8;

  // AHB-Lite encodings
  localparam logic [1:0] SSF_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] SSF_HTRANS_SEQ    = 2'h3;
endpackage

// ===== rtl/ssf_rx_check.sv
// Frame checker: parity and stop bit evaluation of a received frame
`timescale 1ns/1ps
module ssf_rx_check
  import ssf_pkg::*;
(
  // Frame content
  input  wire logic [7:0] frame_data,
  input  wire logic       frame_parity,
  input  wire logic       frame_stop1,
  // Format
  input  wire logic       sync_mode,
  input  wire logic       parity_en,
  input  wire logic       parity_odd_select,
  // Results
  output logic            framing_bad,
  output logic            parity_bad
);
  //==================================================================
  // Checks apply only in asynchronous mode
  wire ones_odd = ^{frame_data, frame_parity};
  // Second stop bit is never presented here, so it is never checked
  assign framing_bad = !sync_mode && !frame_stop1;
  assign parity_bad  = !sync_mode && parity_en &&
                       (ones_odd != parity_odd_select);
endmodule

// ===== rtl/ssf_core.sv
// Status flag logic of the serial port with an AHB-Lite register slave
//
// Added by the designer: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module ssf_core
  import ssf_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        low_power_entry,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Transmit shifter side
  input  wire logic        tx_shifter_load,
  input  wire logic        tx_last_bit,
  output logic [7:0]       tx_buffer_data,
  output logic             tx_multiproc_out,
  output logic             tx_allowed,
  // Receive shifter side
  input  wire logic        rx_frame_done,
  input  wire logic [7:0]  rx_frame_data,
  input  wire logic        rx_frame_parity,
  input  wire logic        rx_frame_mpbit,
  input  wire logic        rx_frame_stop1,
  output logic             rx_allowed,
  // Interrupt requests
  output logic             tx_empty_irq,
  output logic             rx_full_irq,
  output logic             rx_error_irq
);
  //==================================================================
  // Registers
  logic [7:0]  status_reg;
  logic [7:0]  status_next;
  logic [7:0]  control_reg;
  logic [7:0]  control_next;
  logic [7:0]  format_reg;
  logic [7:0]  tx_buffer_reg;
  logic [7:0]  rx_buffer_reg;
  logic [7:0]  rx_buffer_next;
  logic [7:0]  seen_one_reg;
  logic [7:0]  seen_one_next;
  logic        wr_pend_reg;
  logic        rd_pend_reg;
  logic [7:0]  addr_reg;
  logic [31:0] hrdata_reg;

  //==================================================================
  // Address phase decode
  wire addr_valid = hsel && hready &&
                    (htrans == SSF_HTRANS_NONSEQ || htrans == SSF_HTRANS_SEQ);
  wire rd_take = addr_valid && !hwrite;
  wire wr_take = addr_valid && hwrite;

  // Data phase write strobes, one per writable register (status, control, tx buffer, format)
  wire wr_status  = wr_pend_reg && addr_reg == SSF_STATUS_OFS;
  wire wr_control = wr_pend_reg && addr_reg == SSF_CONTROL_OFS;
  wire wr_txbuf   = wr_pend_reg && addr_reg == SSF_TXBUF_OFS;
  wire wr_format  = wr_pend_reg && addr_reg == SSF_FORMAT_OFS;
  wire [7:0] wbyte = hwdata[7:0];

  // Read strobes act at the address phase, data returned next cycle
  wire rd_status = rd_take && haddr == SSF_STATUS_OFS;
  wire rd_rxbuf  = rd_take && haddr == SSF_RXBUF_OFS;

  //==================================================================
  // Mode and control decode
  wire sync_mode = format_reg[SSF_FMT_SYNC];
  wire mp_mode   = format_reg[SSF_FMT_MP] && !sync_mode;
  wire tx_en     = control_reg[SSF_CTL_TE];
  wire rx_en     = control_reg[SSF_CTL_RE];
  wire mp_wait   = control_reg[SSF_CTL_MULTIPROC_IRQ_ENABLE] && mp_mode;
  wire tx_en_fall = control_reg[SSF_CTL_TE] && wr_control && !wbyte[SSF_CTL_TE];

  // Any receive error blocks the receive path
  wire err_any = status_reg[SSF_OVR] | status_reg[SSF_FRM] | status_reg[SSF_PAR];
  assign rx_allowed = rx_en && !err_any;
  // Synchronous mode stops transmit on any receive error too
  assign tx_allowed = tx_en && !(sync_mode && err_any);

  //==================================================================
  // Frame evaluation
  logic framing_bad;
  logic parity_bad;

  ssf_rx_check u_check (
    .frame_data        (rx_frame_data),
    .frame_parity      (rx_frame_parity),
    .frame_stop1       (rx_frame_stop1),
    .sync_mode         (sync_mode),
    .parity_en         (format_reg[SSF_FMT_PEN]),
    .parity_odd_select (format_reg[SSF_FMT_ODD]),
    .framing_bad       (framing_bad),
    .parity_bad        (parity_bad)
  );

  // Frames are ignored while disabled, halted or waiting for an mp id
  wire frame_live = rx_frame_done && rx_allowed;
  wire id_frame   = frame_live && mp_mode && rx_frame_mpbit;
  wire frame_acc  = frame_live && (!mp_wait || rx_frame_mpbit);
  wire overrun    = frame_acc && status_reg[SSF_RDF];
  wire frame_bad  = framing_bad | parity_bad;
  wire frame_good = frame_acc && !overrun && !frame_bad;
  wire frame_err  = frame_acc && !overrun && frame_bad;

  //==================================================================
  // Software clear of a flag: a 0 written after a 1 was read
  wire [7:0] sw_clear = {8{wr_status}} & ~wbyte & seen_one_reg &
                        SSF_CLEARABLE;

  // Status next value; hardware sets are applied after clears
  always_comb begin
    status_next = status_reg;
    // Clears first, so a set in the same cycle wins
    status_next = status_next & ~sw_clear;
    if (wr_txbuf) begin
      status_next[SSF_TDE] = 1'b0;
      status_next[SSF_TND] = 1'b0;
    end
    if (sw_clear[SSF_TDE]) begin
      status_next[SSF_TND] = 1'b0;
    end
    if (rd_rxbuf) begin
      status_next[SSF_RDF] = 1'b0;
    end
    if (tx_shifter_load) begin
      status_next[SSF_TDE] = 1'b1;
    end
    if (tx_last_bit && status_next[SSF_TDE]) begin
      status_next[SSF_TND] = 1'b1;
    end
    if (tx_en_fall) begin
      status_next[SSF_TDE] = 1'b1;
      status_next[SSF_TND] = 1'b1;
    end
    if (frame_good) begin
      status_next[SSF_RDF] = 1'b1;
    end
    if (overrun) begin
      status_next[SSF_OVR] = 1'b1;
    end
    if (frame_err && framing_bad) begin
      status_next[SSF_FRM] = 1'b1;
    end
    if (frame_err && parity_bad) begin
      status_next[SSF_PAR] = 1'b1;
    end
    if (frame_live && mp_mode) begin
      status_next[SSF_MPR] = rx_frame_mpbit;
    end
    if (wr_status) begin
      status_next[SSF_MPT] = wbyte[SSF_MPT];
    end
  end

  // Receive buffer keeps old data on overrun, takes errored data
  assign rx_buffer_next = (frame_good || frame_err) ? rx_frame_data
                                                    : rx_buffer_reg;

  // Control register; mp enable drops itself on an id frame
  always_comb begin
    control_next = control_reg;
    if (wr_control) begin
      control_next = wbyte;
    end
    if (id_frame) begin
      control_next[SSF_CTL_MULTIPROC_IRQ_ENABLE] = 1'b0;
    end
  end

  // Track flags read as 1; a status write consumes the record
  always_comb begin
    seen_one_next = seen_one_reg;
    if (wr_status) begin
      seen_one_next = 8'h00;
    end
    if (rd_status) begin
      seen_one_next = status_reg & SSF_CLEARABLE;
    end
  end

  //==================================================================
  // Status and control state; low-power entry acts like reset
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      status_reg   <= SSF_STATUS_RST;
      control_reg  <= SSF_CONTROL_RST;
      seen_one_reg <= 8'h00;
    end else if (low_power_entry) begin
      status_reg   <= SSF_STATUS_RST;
      control_reg  <= SSF_CONTROL_RST;
      seen_one_reg <= 8'h00;
    end else begin
      status_reg   <= status_next;
      control_reg  <= control_next;
      seen_one_reg <= seen_one_next;
    end
  end

  // Data registers and format
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      format_reg    <= SSF_FORMAT_RST;
      tx_buffer_reg <= 8'h00;
      rx_buffer_reg <= 8'h00;
    end else begin
      format_reg    <= wr_format ? wbyte : format_reg;
      tx_buffer_reg <= wr_txbuf ? wbyte : tx_buffer_reg;
      rx_buffer_reg <= rx_buffer_next;
    end
  end

  //==================================================================
  // Bus phase tracking; the slave never inserts wait states
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
    end else begin
      wr_pend_reg <= wr_take;
      rd_pend_reg <= rd_take;
      addr_reg    <= addr_valid ? haddr : addr_reg;
    end
  end

  // Read mux; unmapped offsets read as zero
  wire [7:0] irq_view = {5'h00, rx_error_irq, rx_full_irq, tx_empty_irq};
  wire [7:0] rd_byte =
    (haddr == SSF_STATUS_OFS)  ? status_reg    :
    (haddr == SSF_CONTROL_OFS) ? control_reg   :
    (haddr == SSF_TXBUF_OFS)   ? tx_buffer_reg :
    (haddr == SSF_RXBUF_OFS)   ? rx_buffer_reg :
    (haddr == SSF_FORMAT_OFS)  ? format_reg    :
    (haddr == SSF_IRQ_OFS)     ? irq_view      : 8'h00;

  // Read data captured at the address phase, held until next read
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (rd_take) begin
      hrdata_reg <= {24'h00_0000, rd_byte};
    end
  end

  assign hrdata    = hrdata_reg;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  //==================================================================
  // Transmit side outputs; mp bit only meaningful in async mp mode
  assign tx_buffer_data   = tx_buffer_reg;
  assign tx_multiproc_out = mp_mode & status_reg[SSF_MPT];

  // Interrupt requests follow their flags and enables directly
  assign tx_empty_irq = control_reg[SSF_CTL_TIE] & status_reg[SSF_TDE];
  assign rx_full_irq  = control_reg[SSF_CTL_RIE] & status_reg[SSF_RDF];
  assign rx_error_irq = control_reg[SSF_CTL_RIE] & err_any;

  // Rx disable touches no flag: only frame events set the receive flags
endmodule

// ===== verif/ssf_chk.sv
// Port assertions for the serial status flag core
`timescale 1ns/1ps
module ssf_chk
  import ssf_pkg::*;
(
  // Clock, reset, power
  input wire logic       clock,
  input wire logic       arst_n,
  input wire logic       low_power_entry,
  // Bus
  input wire logic       hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic       hwrite,
  input wire logic       hready,
  // Shifters
  input wire logic       tx_shifter_load,
  input wire logic       tx_multiproc_out,
  input wire logic       tx_allowed,
  input wire logic       rx_frame_done,
  input wire logic       rx_frame_mpbit,
  input wire logic       rx_allowed,
  // Requests
  input wire logic       tx_empty_irq,
  input wire logic       rx_full_irq,
  input wire logic       rx_error_irq
);
  //==================================================================
  // Address phase decode; the data lands one cycle later
  wire bus_acc = hsel && hready && htrans[1];
  wire bus_wr  = bus_acc && hwrite;
  wire rd_rx   = bus_acc && !hwrite && haddr == SSF_RXBUF_OFS;
  wire wr_tx   = bus_wr && haddr == SSF_TXBUF_OFS;
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  //==================================================================
  property p_lp_init;
    low_power_entry |=> !tx_allowed && !rx_allowed && !tx_empty_irq && !rx_full_irq;
  endproperty
  a_lp_init: assert property (p_lp_init)
    else $error("controls survive power entry");
  // Mp-bit set avoids the discard of the address wait state
  property p_ovr_halt;
    rx_frame_done && rx_frame_mpbit && rx_allowed && rx_full_irq |=> !rx_allowed;
  endproperty
  a_ovr_halt: assert property (p_ovr_halt)
    else $error("receive not halted by overrun");
  property p_ovr_keep;
    rx_frame_done && rx_full_irq && !bus_acc && !$past(bus_acc) && !low_power_entry
      |=> rx_full_irq;
  endproperty
  a_ovr_keep: assert property (p_ovr_keep)
    else $error("buffer full lost on overrun");
  property p_err_block;
    rx_error_irq |-> !rx_allowed;
  endproperty
  a_err_block: assert property (p_err_block)
    else $error("receive allowed with error flag");
  property p_txbuf_clr;
    wr_tx && tx_allowed ##1 !tx_shifter_load && !low_power_entry |=> !tx_empty_irq;
  endproperty
  a_txbuf_clr: assert property (p_txbuf_clr)
    else $error("tx empty request after buffer write");
  property p_rd_clr;
    rd_rx && !rx_frame_done ##1 !rx_frame_done [*2] |-> !rx_full_irq;
  endproperty
  a_rd_clr: assert property (p_rd_clr)
    else $error("buffer full kept after data read");
  property p_err_hold;
    rx_error_irq && !low_power_entry && !$past(bus_wr) |=> rx_error_irq;
  endproperty
  a_err_hold: assert property (p_err_hold)
    else $error("error request dropped without write");
  property p_mpt_hold;
    !bus_wr ##1 !low_power_entry |=> $stable(tx_multiproc_out);
  endproperty
  a_mpt_hold: assert property (p_mpt_hold)
    else $error("sent mp bit moved without write");
  // Main scenarios
  c_overrun: cover property (rx_frame_done && rx_full_irq);
  c_txwrite: cover property (wr_tx && tx_allowed);
  c_error: cover property (rx_error_irq);
endmodule

// ===== verif/ssf_line_model.sv
// Behavioural far side: received frames and transmit shifter events
`timescale 1ns/1ps
module ssf_line_model (
  // Clock
  input wire logic clock,
  // Received frame
  output logic       frame_done,
  output logic [7:0] frame_data,
  output logic       frame_parity,
  output logic       frame_mpbit,
  output logic       frame_stop1,
  // Shifter events
  output logic       shift_load,
  output logic       last_bit
);
  initial {frame_done, frame_data, frame_parity, frame_mpbit, frame_stop1} = '0;
  initial {shift_load, last_bit} = '0;
  // One frame; fields inverted after so stale values never match
  task automatic send(input logic [7:0] d, input logic p, input logic m, input logic s);
    @(posedge clock);
    frame_done <= 1'b1;
    {frame_data, frame_parity, frame_mpbit, frame_stop1} <= {d, p, m, s};
    @(posedge clock);
    frame_done <= 1'b0;
    {frame_data, frame_parity, frame_mpbit, frame_stop1} <= ~{d, p, m, s};
  endtask
  // Shifter takes the buffer, then the last bit leaves
  task automatic shift();
    @(posedge clock);
    shift_load <= 1'b1;
    @(posedge clock);
    shift_load <= 1'b0;
    last_bit <= 1'b1;
    @(posedge clock);
    last_bit <= 1'b0;
  endtask
endmodule

// ===== verif/serial_status_flags_tb_top.sv
// Self-checking bench for the serial status flag core
`timescale 1ns/1ps
module serial_status_flags_tb_top import ssf_pkg::*;;
  logic clock = 0, arst_n = 0, low_power_entry = 0, hsel = 0, hwrite = 0;
  logic [7:0] haddr = '0, tx_buffer_data, rx_frame_data;
  logic [1:0] htrans = '0;
  logic [31:0] hwdata = '0, hrdata, rv;
  logic hreadyout, hresp, tx_shifter_load, tx_last_bit, tx_multiproc_out, tx_allowed;
  logic rx_frame_done, rx_frame_parity, rx_frame_mpbit, rx_frame_stop1, rx_allowed;
  logic tx_empty_irq, rx_full_irq, rx_error_irq;
  int n_errors = 0, n_compared = 0, cyc = 0;
  always #2 clock = ~clock;
  ssf_core i_ssf_core (.clock, .arst_n, .low_power_entry, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .tx_shifter_load,
    .tx_last_bit, .tx_buffer_data, .tx_multiproc_out, .tx_allowed, .rx_frame_done,
    .rx_frame_data, .rx_frame_parity, .rx_frame_mpbit, .rx_frame_stop1, .rx_allowed,
    .tx_empty_irq, .rx_full_irq, .rx_error_irq);
  ssf_line_model i_ssf_line_model (.clock, .frame_done(rx_frame_done),
    .frame_data(rx_frame_data), .frame_parity(rx_frame_parity), .frame_mpbit(rx_frame_mpbit),
    .frame_stop1(rx_frame_stop1), .shift_load(tx_shifter_load), .last_bit(tx_last_bit));
  //==================================================================
  task automatic close_out();
    if (n_errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Single transfer; waits on hready in both phases
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= SSF_HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rv, exp);
  endtask
  // Hang guard, far above the roughly 140 cycles used
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      close_out();
    end
  end
  //==================================================================
  initial begin
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    rd(SSF_STATUS_OFS, 32'h84);
    rd(8'h18, 32'h0);
    wr(SSF_CONTROL_OFS, 32'hf0);
    wr(SSF_STATUS_OFS, 32'hff);
    wr(SSF_STATUS_OFS, 32'h00);
    rd(SSF_STATUS_OFS, 32'h84);
    wr(SSF_STATUS_OFS, 32'hff);
    rd(SSF_STATUS_OFS, 32'h85);
    #1 chk(tx_empty_irq, 32'h1);
    chk(tx_multiproc_out, 32'h0);
    wr(SSF_FORMAT_OFS, 32'h04);
    #1 chk(tx_multiproc_out, 32'h1);
    wr(SSF_FORMAT_OFS, 32'h84);
    #1 chk(tx_multiproc_out, 32'h0);
    wr(SSF_FORMAT_OFS, 32'h00);
    // Buffer write, then shifter load and last bit
    wr(SSF_TXBUF_OFS, 32'h5a);
    rd(SSF_STATUS_OFS, 32'h01);
    chk(tx_buffer_data, 32'h5a);
    i_ssf_line_model.shift();
    rd(SSF_STATUS_OFS, 32'h85);
    // Good frame, then overrun on a full buffer
    i_ssf_line_model.send(8'h3c, 1'b0, 1'b0, 1'b1);
    rd(SSF_STATUS_OFS, 32'hc5);
    rd(SSF_RXBUF_OFS, 32'h3c);
    i_ssf_line_model.send(8'h11, 1'b0, 1'b0, 1'b1);
    i_ssf_line_model.send(8'h22, 1'b0, 1'b1, 1'b1);
    rd(SSF_STATUS_OFS, 32'he5);
    #1 chk(rx_error_irq, 32'h1);
    rd(SSF_RXBUF_OFS, 32'h11);
    wr(SSF_CONTROL_OFS, 32'he0);
    rd(SSF_STATUS_OFS, 32'ha5);
    wr(SSF_STATUS_OFS, 32'h81);
    rd(SSF_STATUS_OFS, 32'h85);
    wr(SSF_CONTROL_OFS, 32'hf0);
    // Framing error stores data and halts reception
    i_ssf_line_model.send(8'h77, 1'b0, 1'b0, 1'b0);
    rd(SSF_STATUS_OFS, 32'h95);
    #1 chk(rx_allowed, 32'h0);
    chk(tx_allowed, 32'h1);
    i_ssf_line_model.send(8'h99, 1'b0, 1'b0, 1'b1);
    rd(SSF_RXBUF_OFS, 32'h77);
    wr(SSF_STATUS_OFS, 32'h81);
    // Even parity fails, odd parity passes
    wr(SSF_FORMAT_OFS, 32'h20);
    i_ssf_line_model.send(8'h01, 1'b0, 1'b0, 1'b1);
    rd(SSF_STATUS_OFS, 32'h8d);
    rd(SSF_RXBUF_OFS, 32'h01);
    wr(SSF_STATUS_OFS, 32'h81);
    wr(SSF_FORMAT_OFS, 32'h30);
    i_ssf_line_model.send(8'h01, 1'b0, 1'b0, 1'b1);
    rd(SSF_STATUS_OFS, 32'hc5);
    rd(SSF_RXBUF_OFS, 32'h01);
    // Address wait: mp bit 1 wakes the receiver
    wr(SSF_FORMAT_OFS, 32'h04);
    wr(SSF_CONTROL_OFS, 32'hf8);
    i_ssf_line_model.send(8'h41, 1'b0, 1'b1, 1'b1);
    rd(SSF_STATUS_OFS, 32'hc7);
    rd(SSF_CONTROL_OFS, 32'hf0);
    @(posedge clock);
    low_power_entry <= 1'b1;
    @(posedge clock);
    low_power_entry <= 1'b0;
    rd(SSF_STATUS_OFS, 32'h84);
    rd(SSF_CONTROL_OFS, 32'h00);
    close_out();
  end
endmodule
bind ssf_core ssf_chk i_ssf_chk (.clock, .arst_n, .low_power_entry, .hsel, .haddr, .htrans,
  .hwrite, .hready, .tx_shifter_load, .tx_multiproc_out, .tx_allowed, .rx_frame_done,
  .rx_frame_mpbit, .rx_allowed, .tx_empty_irq, .rx_full_irq, .rx_error_irq);
